// File: fspk_pkg.sv
// Constants for the flash status and protection key block.
// Assumes a 32-bit APB with byte addresses and the 10 MHz pclk.
package fspk_pkg;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [31:0] FSPK_ADDR_DBG_MODE  = 32'hFFFF_E510;
    localparam logic [31:0] FSPK_ADDR_DBG_KEY   = 32'hFFFF_E514;
    localparam logic [31:0] FSPK_ADDR_ROM_CTRL  = 32'hFFFF_E518;
    localparam logic [31:0] FSPK_ADDR_ROM_KEY   = 32'hFFFF_E51C;
    localparam logic [31:0] FSPK_ADDR_FLASH_STS = 32'hFFFF_E520;

    // ************************************************************
    // Key values and field positions
    // ************************************************************
    localparam logic [31:0] FSPK_ROM_KEY_VAL    = 32'h0000_003D;
    localparam logic [31:0] FSPK_DBG_KEY_VAL    = 32'h0000_00C5;
    localparam int          FSPK_BIT_READY      = 0;
    localparam int          FSPK_BIT_ROM_TYPE   = 2;
    localparam int          FSPK_PROT_LSB       = 4;
    localparam int          FSPK_PROT_MSB       = 7;
    localparam int          FSPK_BIT_GUARD_ON   = 0;
    localparam int          FSPK_NUM_BLOCKS     = 4;

    // ************************************************************
    // Reset values, all-protect pattern and full byte strobe
    // ************************************************************
    localparam logic [31:0] FSPK_RST_WORD       = 32'h0000_0000;
    localparam logic        FSPK_RST_READY      = 1'b1;
    localparam logic        FSPK_RST_GUARD_ON   = 1'b1;
    localparam logic        FSPK_RST_DBG_OFF    = 1'b1;
    localparam logic [3:0]  FSPK_RST_PROT       = 4'h0;
    localparam logic [3:0]  FSPK_ALL_PROT       = 4'hF;
    localparam logic [3:0]  FSPK_FULL_STRB      = 4'hF;

    // ************************************************************
    // Flash operation states
    // ************************************************************
    typedef enum logic [1:0] {
        FSPK_ST_READY = 2'b00,
        FSPK_ST_BUSY  = 2'b01,
        FSPK_ST_FAULT = 2'b10
    } fspk_state_t;

endpackage : fspk_pkg

// File: fspk_top.sv
// Flash ready flag, block protect status and ROM/debug guard key registers.
// Assumes an APB master on pclk and a flash sequencer on the same clock;
// por_n and presetn are asynchronous, active low.
//
// Function
// R1: Ready flag low while busy, accept when high
// R2: Faulted operation keeps ready flag low
// R3: Hardware reset restores ready flag high
// R4: Software checks ready before issuing commands
// R5: System reset or reset command recovers
// R6: Bit 2 shows ROM type, mask is 1
// R7: Bits 7:4 show per-block protect status
// R8: Writes to protected blocks are refused
// R9: Guard regs: power-on reset only on flash
// R10: Software uses full 32-bit accesses only
// R11: Key 0x3D commits pending ROM guard bit
// R12: Protected guard regs reachable only from ROM
// R13: ROM key write-only, reads not data
// R14: Debug key write-only, resets to zero
// R15: Software never relies on key readback
// R16: ROM protection when flash protected and bit set
// R17: ROM guard bit resets to one
// R18: ROM guard changes need value then key
// R19: Debug guard changes need bit then key
// R20: Wrong key leaves protection bits unchanged
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps

module fspk_top
    import fspk_pkg::*;
#(
    parameter bit MASK_ROM = 1'b0
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       por_n,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       rom_fetch,
    input  wire logic                       cmd_req,
    input  wire logic                       reset_cmd,
    input  wire logic                       op_done,
    input  wire logic                       op_fault,
    input  wire logic [FSPK_NUM_BLOCKS-1:0] blk_prot_in,
    input  wire logic                       blk_wr_req,
    input  wire logic [1:0]                 blk_wr_idx,
    output logic                            cmd_go,
    output logic                            blk_wr_ok,
    output logic                            flash_ready_flag,
    output logic                            rom_prot_active,
    output logic                            dbg_prot_active
);

    // ************************************************************
    // Registers
    // ************************************************************
    fspk_state_t                state_r;
    fspk_state_t                state_nxt;
    // Own flop for the flag so the pin never shows a decode glitch
    logic                       ready_r;
    logic                       pready_r;
    logic                       pslverr_r;
    logic [31:0]                prdata_r;
    logic                       cmd_go_r;
    logic                       blk_wr_ok_r;
    logic [FSPK_NUM_BLOCKS-1:0] prot_r;
    logic                       rom_on_r;
    logic                       rom_pend_r;
    logic                       dbg_off_r;
    logic                       dbg_pend_r;
    logic [31:0]                dbg_key_r;
    logic                       rom_prot_r;
    logic                       dbg_prot_r;

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire        acc_phase   = psel & penable;
    wire        acc_done    = acc_phase & pready_r;
    wire        hit_dmode   = (paddr == FSPK_ADDR_DBG_MODE);
    wire        hit_dkey    = (paddr == FSPK_ADDR_DBG_KEY);
    wire        hit_rctrl   = (paddr == FSPK_ADDR_ROM_CTRL);
    wire        hit_rkey    = (paddr == FSPK_ADDR_ROM_KEY);
    wire        hit_sts     = (paddr == FSPK_ADDR_FLASH_STS);
    wire        hit_guard   = hit_dmode | hit_dkey | hit_rctrl | hit_rkey;
    wire        hit_any     = hit_guard | hit_sts;
    // Narrow writes refused rather than merged half-way into a key
    wire        narrow_wr   = pwrite & (pstrb != FSPK_FULL_STRB);
    // Guard registers locked against code outside ROM
    wire        lock_viol   = hit_guard & rom_prot_r & ~rom_fetch;    // see R12
    wire        sts_wr      = hit_sts & pwrite;
    wire        acc_err     = ~hit_any | narrow_wr | lock_viol | sts_wr;
    wire        wr_ok       = acc_done & pwrite & ~acc_err;
    wire        wr_dmode    = wr_ok & hit_dmode;
    wire        wr_dkey     = wr_ok & hit_dkey;
    wire        wr_rctrl    = wr_ok & hit_rctrl;
    wire        wr_rkey     = wr_ok & hit_rkey;
    wire        rkey_match  = (pwdata == FSPK_ROM_KEY_VAL);           // see R20
    wire        dkey_match  = (pwdata == FSPK_DBG_KEY_VAL);           // see R20
    wire        ready_bit   = (state_r == FSPK_ST_READY);
    wire        flash_prot  = MASK_ROM | (prot_r == FSPK_ALL_PROT);

    // Key registers read as zero, never as the stored value
    wire [31:0] sts_word    = {24'h00_0000, prot_r, 1'b0, MASK_ROM,
                               1'b0, ready_bit};                      // see R6, R7
    wire [31:0] rctrl_word  = {31'h0000_0000, rom_on_r};
    wire [31:0] dmode_word  = {31'h0000_0000, dbg_off_r};
    wire [31:0] rd_word     = (hit_sts   & ~acc_err) ? sts_word   :
                              (hit_rctrl & ~acc_err) ? rctrl_word :
                              (hit_dmode & ~acc_err) ? dmode_word :
                              FSPK_RST_WORD;                          // see R13, R14

    // Guard registers follow the power-on reset only on the flash part
    wire        guard_rst_n = MASK_ROM ? (presetn & por_n) : por_n;   // see R9

    // ************************************************************
    // APB slave: one wait state, answer from flops
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= FSPK_RST_WORD;
        end else begin
            pready_r  <= acc_phase & ~pready_r;
            pslverr_r <= acc_phase & ~pready_r & acc_err;
            prdata_r  <= (acc_phase & ~pready_r & ~pwrite) ? rd_word : FSPK_RST_WORD;
        end
    end

    // ************************************************************
    // Ready/busy state
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            FSPK_ST_READY: begin
                if (cmd_req && !MASK_ROM) begin
                    state_nxt = FSPK_ST_BUSY;                         // see R1
                end
            end
            FSPK_ST_BUSY: begin
                if (op_done && op_fault) begin
                    state_nxt = FSPK_ST_FAULT;                        // see R2
                end else if (op_done) begin
                    state_nxt = FSPK_ST_READY;                        // see R1
                end
            end
            FSPK_ST_FAULT: begin
                state_nxt = FSPK_ST_FAULT;                            // see R2
            end
            default: begin
                state_nxt = FSPK_ST_READY;
            end
        endcase
        if (reset_cmd) begin
            state_nxt = FSPK_ST_READY;                                // see R5
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r  <= FSPK_ST_READY;                                // see R3
            ready_r  <= FSPK_RST_READY;                               // see R3
            cmd_go_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            ready_r  <= (state_nxt == FSPK_ST_READY);                 // see R1, R2
            cmd_go_r <= cmd_req & ready_bit & ~reset_cmd & ~MASK_ROM; // see R1
        end
    end

    // ************************************************************
    // Block protect status and write gate
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prot_r      <= FSPK_RST_PROT;
            blk_wr_ok_r <= 1'b0;
        end else begin
            prot_r      <= blk_prot_in;                               // see R7
            blk_wr_ok_r <= blk_wr_req & ~prot_r[blk_wr_idx];          // see R8
        end
    end

    // ************************************************************
    // Guard bits: staged value, committed by key
    // ************************************************************
    // A wrong key leaves the live bit alone; staged value persists
    always_ff @(posedge pclk or negedge guard_rst_n) begin
        if (!guard_rst_n) begin
            rom_on_r   <= FSPK_RST_GUARD_ON;                          // see R17
            rom_pend_r <= FSPK_RST_GUARD_ON;
            dbg_off_r  <= FSPK_RST_DBG_OFF;
            dbg_pend_r <= FSPK_RST_DBG_OFF;
            dbg_key_r  <= FSPK_RST_WORD;                              // see R14
        end else begin
            if (wr_rctrl) begin
                rom_pend_r <= pwdata[FSPK_BIT_GUARD_ON];              // see R18
            end
            if (wr_rkey && rkey_match) begin
                rom_on_r <= rom_pend_r;                               // see R11, R18
            end
            if (wr_dmode) begin
                dbg_pend_r <= pwdata[FSPK_BIT_GUARD_ON];              // see R19
            end
            if (wr_dkey) begin
                dbg_key_r <= pwdata;
            end
            if (wr_dkey && dkey_match) begin
                dbg_off_r <= dbg_pend_r;                              // see R19
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rom_prot_r <= 1'b0;
            dbg_prot_r <= 1'b0;
        end else begin
            rom_prot_r <= flash_prot & rom_on_r;                      // see R16
            dbg_prot_r <= flash_prot & dbg_off_r;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign cmd_go           = cmd_go_r;
    assign blk_wr_ok        = blk_wr_ok_r;
    assign flash_ready_flag = ready_r;
    assign rom_prot_active  = rom_prot_r;
    assign dbg_prot_active  = dbg_prot_r;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_busy_after_go;
        @(posedge pclk) disable iff (!presetn)
        $rose(cmd_go) |-> !flash_ready_flag;
    endproperty
    a_busy_after_go: assert property (p_busy_after_go)              // see R1
        else $error("flag high right after command start");

    property p_no_go_when_busy;
        @(posedge pclk) disable iff (!presetn)
        (!flash_ready_flag) |=> !cmd_go || $past(reset_cmd);
    endproperty
    a_no_go_when_busy: assert property (p_no_go_when_busy)          // see R1
        else $error("command accepted while busy");

    property p_fault_stays_low;
        @(posedge pclk) disable iff (!presetn)
        (state_r == FSPK_ST_BUSY && op_done && op_fault && !reset_cmd)
            |=> !flash_ready_flag ##1 (!flash_ready_flag || $past(reset_cmd));
    endproperty
    a_fault_stays_low: assert property (p_fault_stays_low)          // see R2
        else $error("flag rose after faulted operation");

    property p_reset_cmd_recovers;
        @(posedge pclk) disable iff (!presetn)
        reset_cmd |=> flash_ready_flag;
    endproperty
    a_reset_cmd_recovers: assert property (p_reset_cmd_recovers)    // see R5
        else $error("reset command did not restore ready");

    property p_sts_read;
        @(posedge pclk) disable iff (!presetn)
        (acc_phase && !pready_r && !pwrite && hit_sts)
            |=> prdata[FSPK_BIT_READY] == $past(ready_bit)
             && prdata[FSPK_BIT_ROM_TYPE] == MASK_ROM
             && prdata[FSPK_PROT_MSB:FSPK_PROT_LSB] == $past(prot_r);
    endproperty
    a_sts_read: assert property (p_sts_read)                        // see R6, R7
        else $error("status word does not match state");

    property p_blk_refused;
        @(posedge pclk) disable iff (!presetn)
        (blk_wr_req && prot_r[blk_wr_idx]) |=> !blk_wr_ok;
    endproperty
    a_blk_refused: assert property (p_blk_refused)                  // see R8
        else $error("write to protected block allowed");

    property p_rom_commit;
        @(posedge pclk) disable iff (!presetn || !guard_rst_n)
        (wr_rkey && rkey_match) |=> rom_on_r == $past(rom_pend_r);
    endproperty
    a_rom_commit: assert property (p_rom_commit)                    // see R11, R18
        else $error("ROM key did not commit staged bit");

    property p_wrong_key_keeps;
        @(posedge pclk) disable iff (!presetn || !guard_rst_n)
        (!(wr_rkey && rkey_match) && !(wr_dkey && dkey_match))
            |=> $stable(rom_on_r) && $stable(dbg_off_r);
    endproperty
    a_wrong_key_keeps: assert property (p_wrong_key_keeps)          // see R20
        else $error("guard bit changed without key");

    property p_lock_refused;
        @(posedge pclk) disable iff (!presetn)
        (acc_phase && !pready_r && hit_guard && rom_prot_r && !rom_fetch)
            |=> pready && pslverr;
    endproperty
    a_lock_refused: assert property (p_lock_refused)                // see R12
        else $error("locked guard access not refused");

    property p_key_reads_zero;
        @(posedge pclk) disable iff (!presetn)
        (acc_phase && !pready_r && !pwrite && (hit_rkey || hit_dkey))
            |=> prdata == FSPK_RST_WORD;
    endproperty
    a_key_reads_zero: assert property (p_key_reads_zero)            // see R13, R14
        else $error("key register value leaked on read");

    property p_rom_prot_follow;
        @(posedge pclk) disable iff (!presetn)
        ##1 rom_prot_active == $past(flash_prot && rom_on_r);
    endproperty
    a_rom_prot_follow: assert property (p_rom_prot_follow)          // see R16
        else $error("ROM protection state wrong");

    property p_ready_after_done;
        @(posedge pclk) disable iff (!presetn)
        (state_r == FSPK_ST_BUSY && op_done && !op_fault) |=> flash_ready_flag;
    endproperty
    a_ready_after_done: assert property (p_ready_after_done)        // see R1
        else $error("flag stayed low after clean operation end");

    property p_dbg_commit;
        @(posedge pclk) disable iff (!presetn || !guard_rst_n)
        (wr_dkey && dkey_match) |=> dbg_off_r == $past(dbg_pend_r);
    endproperty
    a_dbg_commit: assert property (p_dbg_commit)                    // see R19
        else $error("debug key did not commit staged bit");

    property p_locked_write_ignored;
        @(posedge pclk) disable iff (!presetn || !guard_rst_n)
        (acc_done && pwrite && lock_viol)
            |=> $stable(rom_pend_r) && $stable(dbg_pend_r);
    endproperty
    a_locked_write_ignored: assert property (p_locked_write_ignored) // see R12
        else $error("locked guard write took effect");

endmodule : fspk_top

// File: fspk_tb_top.sv
// Self-checking bench for the flash status and protection key block.
// Assumes fspk_pkg and fspk_top (flash variant); the bench is the APB master.
`timescale 1ns/1ps

module fspk_tb_top import fspk_pkg::*;;

    logic        pclk, presetn, por_n, psel, penable, pwrite;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0]  pstrb, blk_prot_in;
    logic        pready, pslverr, rom_fetch, cmd_req, reset_cmd, op_done, op_fault;
    logic        blk_wr_req, cmd_go, blk_wr_ok, flash_ready_flag;
    logic        rom_prot_active, dbg_prot_active;
    logic [1:0]  blk_wr_idx;
    int          miscompares = 0;
    int          n_tests     = 0;
    int          cycles      = 0;

    fspk_top #(.MASK_ROM(1'b0)) u_dut (
        .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rom_fetch(rom_fetch), .cmd_req(cmd_req),
        .reset_cmd(reset_cmd), .op_done(op_done), .op_fault(op_fault),
        .blk_prot_in(blk_prot_in), .blk_wr_req(blk_wr_req), .blk_wr_idx(blk_wr_idx),
        .cmd_go(cmd_go), .blk_wr_ok(blk_wr_ok), .flash_ready_flag(flash_ready_flag),
        .rom_prot_active(rom_prot_active), .dbg_prot_active(dbg_prot_active)
    );

    // ************************************************************
    // Clock, timeout and verdict
    // ************************************************************
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic stop_test;
        if (miscompares == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    // Whole run needs well under 2000 cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            $display("wrong value at %0t: run did not finish", $time);
            stop_test();
        end
    end

    // ************************************************************
    // Shared helpers
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    // One APB transfer; pready, prdata and pslverr taken at the completing rising edge
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk(n, 32'd2, "wait states before pready");
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic e);
        logic [31:0] r;
        logic        x;
        apb(1'b1, a, d, s, r, x);
        chk({31'h0, x}, {31'h0, e}, "write error response");
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic e);
        logic [31:0] r;
        logic        x;
        apb(1'b0, a, 32'h0, 4'h0, r, x);
        chk({31'h0, x}, {31'h0, e}, "read error response");
        if (!e) begin
            chk(r, d, "read data");
        end
    endtask : rd

    task automatic do_reset(input logic por);
        @(posedge pclk);
        presetn <= 1'b0;
        por_n   <= ~por;
        @(negedge pclk);
        chk({31'h0, flash_ready_flag}, 32'h1, "ready flag in reset");
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        por_n   <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask : do_reset

    // Command pulse; exp_go says whether it must be accepted
    task automatic cmd(input logic exp_go);
        @(posedge pclk);
        chk({31'h0, flash_ready_flag}, {31'h0, exp_go}, "ready before command");
        cmd_req <= 1'b1;
        @(posedge pclk);
        cmd_req <= 1'b0;
        @(negedge pclk);
        chk({30'h0, cmd_go, flash_ready_flag}, {30'h0, exp_go, 1'b0}, "accept, busy");
    endtask : cmd

    task automatic end_op(input logic fault);
        @(posedge pclk);
        op_done  <= 1'b1;
        op_fault <= fault;
        @(posedge pclk);
        op_done  <= 1'b0;
        op_fault <= 1'b0;
        repeat (4) @(negedge pclk);
        chk({31'h0, flash_ready_flag}, {31'h0, ~fault}, "ready after operation");
    endtask : end_op

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_flash;
        cmd(1'b1);
        cmd(1'b0);
        end_op(1'b0);
        cmd(1'b1);
        end_op(1'b1);
        @(posedge pclk);
        reset_cmd <= 1'b1;
        @(posedge pclk);
        reset_cmd <= 1'b0;
        @(negedge pclk);
        chk({31'h0, flash_ready_flag}, 32'h1, "ready after reset command");
        cmd(1'b1);
        end_op(1'b1);
        do_reset(1'b0);
        cmd(1'b1);
        end_op(1'b0);
    endtask : t_flash

    task automatic t_prot;
        @(posedge pclk);
        blk_prot_in <= 4'h5;
        repeat (3) @(posedge pclk);
        rd(FSPK_ADDR_FLASH_STS, 32'h0000_0051, 1'b0);
        wr(FSPK_ADDR_FLASH_STS, 32'h0000_0000, FSPK_FULL_STRB, 1'b1);
        rd(32'hFFFF_E524, 32'h0, 1'b1);
        wr(FSPK_ADDR_ROM_CTRL, 32'h0, 4'h1, 1'b1);
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            blk_wr_req <= 1'b1;
            blk_wr_idx <= i[1:0];
            @(posedge pclk);
            blk_wr_req <= 1'b0;
            @(negedge pclk);
            chk({31'h0, blk_wr_ok}, {31'h0, ~blk_prot_in[i]}, "block write");
        end
    endtask : t_prot

    task automatic t_guard;
        @(posedge pclk);
        blk_prot_in <= FSPK_ALL_PROT;
        repeat (4) @(posedge pclk);
        chk({30'h0, rom_prot_active, dbg_prot_active}, 32'h3, "guards on");
        wr(FSPK_ADDR_ROM_CTRL, 32'h0, FSPK_FULL_STRB, 1'b1);
        rd(FSPK_ADDR_ROM_KEY, 32'h0, 1'b1);
        rom_fetch <= 1'b1;
        wr(FSPK_ADDR_ROM_CTRL, 32'h0, FSPK_FULL_STRB, 1'b0);
        rd(FSPK_ADDR_ROM_CTRL, 32'h1, 1'b0);
        wr(FSPK_ADDR_ROM_KEY, 32'h0000_003C, FSPK_FULL_STRB, 1'b0);
        rd(FSPK_ADDR_ROM_CTRL, 32'h1, 1'b0);
        wr(FSPK_ADDR_ROM_KEY, FSPK_ROM_KEY_VAL, FSPK_FULL_STRB, 1'b0);
        rd(FSPK_ADDR_ROM_CTRL, 32'h0, 1'b0);
        rd(FSPK_ADDR_ROM_KEY, 32'h0, 1'b0);
        chk({31'h0, rom_prot_active}, 32'h0, "rom guard released");
        wr(FSPK_ADDR_DBG_MODE, 32'h0, FSPK_FULL_STRB, 1'b0);
        wr(FSPK_ADDR_DBG_KEY, 32'h0000_01C5, FSPK_FULL_STRB, 1'b0);
        chk({31'h0, dbg_prot_active}, 32'h1, "debug guard kept");
        wr(FSPK_ADDR_DBG_KEY, FSPK_DBG_KEY_VAL, FSPK_FULL_STRB, 1'b0);
        rd(FSPK_ADDR_DBG_MODE, 32'h0, 1'b0);
        rd(FSPK_ADDR_DBG_KEY, 32'h0, 1'b0);
        chk({31'h0, dbg_prot_active}, 32'h0, "debug guard released");
        wr(FSPK_ADDR_ROM_CTRL, 32'h1, FSPK_FULL_STRB, 1'b0);
        wr(FSPK_ADDR_ROM_KEY, FSPK_ROM_KEY_VAL, FSPK_FULL_STRB, 1'b0);
        rom_fetch <= 1'b0;
        rd(FSPK_ADDR_ROM_CTRL, 32'h0, 1'b1);
        do_reset(1'b0);
        chk({30'h0, rom_prot_active, dbg_prot_active}, 32'h2, "guards after reset");
        do_reset(1'b1);
        chk({30'h0, rom_prot_active, dbg_prot_active}, 32'h3, "guards after power-on");
    endtask : t_guard

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {presetn, por_n, psel, penable, pwrite, rom_fetch} = 6'h00;
        {cmd_req, reset_cmd, op_done, op_fault, blk_wr_req} = 5'h00;
        paddr       = 32'h0;
        pwdata      = 32'h0;
        pstrb       = 4'h0;
        blk_prot_in = 4'h0;
        blk_wr_idx  = 2'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        por_n   <= 1'b1;
        rd(FSPK_ADDR_FLASH_STS, 32'h0000_0001, 1'b0);
        rd(FSPK_ADDR_ROM_CTRL, 32'h1, 1'b0);
        rd(FSPK_ADDR_DBG_MODE, 32'h1, 1'b0);
        rd(FSPK_ADDR_DBG_KEY, 32'h0, 1'b0);
        t_flash();
        t_prot();
        t_guard();
        stop_test();
    end

endmodule : fspk_tb_top
